/* logic/cbx_pkg.sv */
// Shared constants, operation codes and bus carriers for the compare/decimal/step execution slice
package cbx_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 8;  // Register bus address width
  localparam int DATA_W = 32;  // Register bus data width
  localparam int WORD_W = 16;  // Operand width
  localparam int WORD_MSB = 15;  // Sign bit of a word
  localparam int BYTE_MSB = 7;  // Sign bit of a byte
  localparam int BCD_DIGITS = 4;  // Packed digits in a word

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFF_SRC = 8'h00;  // Source operand
  localparam logic [ADDR_W-1:0] OFF_DST = 8'h04;  // Destination operand and result
  localparam logic [ADDR_W-1:0] OFF_PSW = 8'h08;  // Processor status word
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h0c;  // Command: a write executes one operation
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h10;  // Interrupt gating state, read only

  // ************************************************************
  // Status word layout and reset values
  // ************************************************************
  localparam int PSW_C = 0;  // Carry
  localparam int PSW_Z = 1;  // Zero
  localparam int PSW_N = 2;  // Negative
  localparam int PSW_GIE = 3;  // Global interrupt enable
  localparam int PSW_CPU_OFF_BIT = 4;  // CPU off
  localparam int PSW_OSCILLATOR_OFF_BIT = 5;  // Oscillator off
  localparam int PSW_V = 8;  // Overflow
  localparam logic [WORD_W-1:0] PSW_RESET = 16'h0000;  // Status word after reset
  localparam logic [WORD_W-1:0] GIE_MASK = 16'h0008;  // Bit 3 mask
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;  // Operand registers after reset
  localparam logic [WORD_W-1:0] BCD_WORD_MAX = 16'h9999;  // Largest packed decimal word
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;  // Zero operand

  // ************************************************************
  // Command layout and addends
  // ************************************************************
  localparam int CMD_OP_LSB = 0;  // Operation code, 3 bits
  localparam int CMD_BYTE_BIT = 8;  // 1 selects the byte form
  localparam int STATE_INHIBIT = 0;  // Interrupt held off after enable
  localparam int STATE_ACCEPT = 1;  // Interrupt may be accepted
  localparam logic [WORD_W-1:0] DEC_ADDEND = 16'hffff;  // Adds minus one
  localparam logic [WORD_W-1:0] SUBTRACT_TWO_OP_ADDEND = 16'hfffe;  // Adds minus two
  localparam logic [WORD_W-1:0] INC_ADDEND = 16'h0001;  // Adds one
  localparam logic [4:0] BCD_DIGIT_MAX = 5'h09;  // Largest digit
  localparam logic [4:0] BCD_ADJUST = 5'h06;  // Decimal correction

  // ************************************************************
  // Bus responses
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;  // Normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address

  // Operation codes
  typedef enum logic [2:0] {
    compare_op = 3'b000,
    bcd_add_op = 3'b001,
    bcd_carry_in_op = 3'b010,
    subtract_one_op = 3'b011,
    subtract_two_op = 3'b100,
    increment_op = 3'b101,
    interrupt_disable_op = 3'b110,
    interrupt_enable_op = 3'b111
  } cbx_op_e;

  // Arithmetic flags of one result
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } cbx_flags_s;

  // Master to slave signals of the register bus
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cbx_axi_req_s;

  // Slave to master signals of the register bus
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } cbx_axi_rsp_s;

endpackage

/* logic/cbx_add_flags.sv */
// Binary adder with word and byte flag generation
`timescale 1ns/1ns
module cbx_add_flags (
  input wire logic [cbx_pkg::WORD_W-1:0] dst,
  input wire logic [cbx_pkg::WORD_W-1:0] addend,
  input wire logic carry_in,
  input wire logic byte_mode,
  output logic [cbx_pkg::WORD_W-1:0] result,
  output cbx_pkg::cbx_flags_s flags
);
  import cbx_pkg::*;

  // ************************************************************
  // Word and byte sums
  // ************************************************************
  logic [WORD_W:0] word_sum;  // 17-bit sum, top bit is word carry
  logic [8:0] byte_sum;  // 9-bit sum, top bit is byte carry

  assign word_sum = {1'b0, dst} + {1'b0, addend} + {16'h0000, carry_in};
  assign byte_sum = {1'b0, dst[7:0]} + {1'b0, addend[7:0]} + {8'h00, carry_in};

  // Byte form works on the low byte only, high byte reads zero
  assign result = byte_mode ? {8'h00, byte_sum[7:0]} : word_sum[WORD_W-1:0];

  // Flags from bit 7 or bit 15 and the matching carry out
  assign flags.n = byte_mode ? byte_sum[BYTE_MSB] : word_sum[WORD_MSB];
  assign flags.z = (result == ZERO_WORD);
  assign flags.c = byte_mode ? byte_sum[8] : word_sum[WORD_W];
  // Signed overflow: like-signed inputs giving a differently signed sum
  assign flags.v = byte_mode ?
    ((dst[BYTE_MSB] == addend[BYTE_MSB]) && (byte_sum[BYTE_MSB] != dst[BYTE_MSB])) :
    ((dst[WORD_MSB] == addend[WORD_MSB]) && (word_sum[WORD_MSB] != dst[WORD_MSB]));

endmodule

/* logic/cbx_bcd_digit.sv */
// One decimal digit adder with carry in and carry out
`timescale 1ns/1ns
module cbx_bcd_digit (
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic carry_in,
  output logic [3:0] sum,
  output logic carry_out
);
  import cbx_pkg::*;

  // ************************************************************
  // Binary sum and decimal correction
  // ************************************************************
  logic [4:0] raw;  // Binary digit sum
  logic [4:0] adjusted;  // Sum with correction added

  assign raw = {1'b0, a} + {1'b0, b} + {4'h0, carry_in};
  assign adjusted = raw + BCD_ADJUST;
  // Above nine the digit wraps and carries; non-decimal inputs give no defined result
  assign carry_out = (raw > BCD_DIGIT_MAX);
  assign sum = carry_out ? adjusted[3:0] : raw[3:0];

endmodule

/* logic/cbx_exec.sv */
// Execution slice: compare, decimal add, steps and interrupt enable control behind a register bus
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
// Functional notes
// - Compare adds inverted source plus one, flags only
// - Compare sets N, Z, C, V from difference
// - Arithmetic operations keep the three mode bits
// - Every operation except interrupt disable and enable has word and byte forms
// - Decimal add-carry equals decimal add of zero
// - Add-carry carry on wrap; N, Z from result
// - Decimal add of source plus carry flag
// - Decimal add carry on decimal overflow, N, Z
// - Subtract one: Z if was one, C unless zero
// - Subtract one overflow at most negative value
// - Subtract two: Z if two, C unless below two
// - Subtract two overflow at two lowest negatives
// - Interrupt disable clears only the enable bit
// - Interrupt may still be taken just after disable
// - Interrupt enable sets only the enable bit
// - Next instruction runs before any interrupt after enable
// - Increment adds one, N from result
// - Increment Z, C at all ones; V at max
module cbx_exec (
  aclk,
  aresetn,
  axi_req,
  axi_rsp,
  irq_request,
  irq_accept
);
  import cbx_pkg::*;

  input wire logic aclk;  // 10 MHz clock
  input wire logic aresetn;  // Synchronous reset, active low
  input wire cbx_pkg::cbx_axi_req_s axi_req;  // Bus master signals
  output cbx_pkg::cbx_axi_rsp_s axi_rsp;  // Bus slave signals
  input wire logic irq_request;  // Pending interrupt, asynchronous pin
  output logic irq_accept;  // Interrupt may be accepted now

  // ************************************************************
  // State
  // ************************************************************
  logic [WORD_W-1:0] src_q, src_d;  // Source operand
  logic [WORD_W-1:0] dst_q, dst_d;  // Destination operand
  logic [WORD_W-1:0] psw_q, psw_d;  // Processor status word
  logic [WORD_W-1:0] cmd_q;  // Last command written
  logic [ADDR_W-1:0] awaddr_q;  // Held write address
  logic [DATA_W-1:0] wdata_q;  // Held write data
  logic [3:0] wstrb_q;  // Held byte enables
  logic aw_have_q, w_have_q;  // Address or data held
  logic awready_q, wready_q, bvalid_q;  // Write channel handshakes
  logic [1:0] bresp_q;  // Write answer
  logic arready_q, rvalid_q;  // Read channel handshakes
  logic [DATA_W-1:0] rdata_q;  // Read data
  logic [1:0] rresp_q;  // Read answer
  logic irq_meta_q, irq_sync_q;  // Interrupt request synchroniser
  logic inhibit_q;  // Interrupt held off after enable
  logic accept_q;  // Registered accept output

  // ************************************************************
  // Bus handshakes and decode
  // ************************************************************
  wire aw_hs = axi_req.awvalid && awready_q;  // Write address taken
  wire w_hs = axi_req.wvalid && wready_q;  // Write data taken
  wire b_hs = bvalid_q && axi_req.bready;  // Write answer taken
  wire ar_hs = axi_req.arvalid && arready_q;  // Read address taken
  wire r_hs = rvalid_q && axi_req.rready;  // Read answer taken
  wire do_write = aw_have_q && w_have_q && !bvalid_q;  // Both halves held
  wire hit_src = (awaddr_q == OFF_SRC);
  wire hit_dst = (awaddr_q == OFF_DST);
  wire hit_psw = (awaddr_q == OFF_PSW);
  wire hit_cmd = (awaddr_q == OFF_CMD);
  wire wr_mapped = hit_src || hit_dst || hit_psw || hit_cmd;  // State is read only
  wire exec = do_write && hit_cmd;  // One operation per command write

  // Merge the low two byte lanes into a 16-bit register
  function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old, input logic [DATA_W-1:0] data,
                                              input logic [3:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ************************************************************
  // Operation decode
  // ************************************************************
  cbx_op_e op;  // Operation of the command being executed
  logic byte_mode;  // Byte form selected
  assign op = cbx_op_e'(wdata_q[CMD_OP_LSB +: 3]);
  assign byte_mode = wdata_q[CMD_BYTE_BIT];
  wire is_bcd = (op == bcd_add_op) || (op == bcd_carry_in_op);
  wire is_gie = (op == interrupt_disable_op) || (op == interrupt_enable_op);

  // Binary addend: inverted source with carry one for compare, fixed steps otherwise
  logic [WORD_W-1:0] addend;
  assign addend = (op == compare_op) ? ~src_q :
                  (op == subtract_one_op) ? DEC_ADDEND :
                  (op == subtract_two_op) ? SUBTRACT_TWO_OP_ADDEND :
                  (op == increment_op) ? INC_ADDEND : ZERO_WORD;
  wire add_cin = (op == compare_op);

  // ************************************************************
  // Binary adder
  // ************************************************************
  logic [WORD_W-1:0] add_res;  // Binary result
  cbx_flags_s add_flags;  // Binary flags
  cbx_add_flags u_add (
    .dst(dst_q),
    .addend(addend),
    .carry_in(add_cin),
    .byte_mode(byte_mode),
    .result(add_res),
    .flags(add_flags)
  );

  // ************************************************************
  // Decimal adder: four chained digits, carry flag enters digit 0
  // ************************************************************
  logic [WORD_W-1:0] bcd_b;  // Source, or zero for add-carry
  logic [WORD_W-1:0] bcd_sum;  // Digit sums
  logic [BCD_DIGITS:0] bcd_c;  // Digit carries
  assign bcd_b = (op == bcd_add_op) ? src_q : ZERO_WORD;
  assign bcd_c[0] = psw_q[PSW_C];
  genvar gi;
  generate
    for (gi = 0; gi < BCD_DIGITS; gi++) begin : g_digit
      cbx_bcd_digit u_digit (
        .a(dst_q[4*gi +: 4]),
        .b(bcd_b[4*gi +: 4]),
        .carry_in(bcd_c[gi]),
        .sum(bcd_sum[4*gi +: 4]),
        .carry_out(bcd_c[gi+1])
      );
    end
  endgenerate
  logic [WORD_W-1:0] bcd_res;  // Decimal result
  cbx_flags_s bcd_flags;  // Decimal flags, V passed through from the status word
  assign bcd_res = byte_mode ? {8'h00, bcd_sum[7:0]} : bcd_sum;
  assign bcd_flags.n = byte_mode ? bcd_sum[BYTE_MSB] : bcd_sum[WORD_MSB];
  assign bcd_flags.z = (bcd_res == ZERO_WORD);
  assign bcd_flags.c = byte_mode ? bcd_c[2] : bcd_c[BCD_DIGITS];
  assign bcd_flags.v = psw_q[PSW_V];

  // ************************************************************
  // Next register values
  // ************************************************************
  cbx_flags_s new_flags;  // Flags of the executed operation
  assign new_flags = is_bcd ? bcd_flags : add_flags;
  wire [WORD_W-1:0] exec_res = is_bcd ? bcd_res : add_res;
  // Only N, Z, C, V change; mode bits pass through untouched
  wire [WORD_W-1:0] flag_psw = {psw_q[15:9], new_flags.v, psw_q[7:3], new_flags.n, new_flags.z, new_flags.c};

  // Destination: result written back except for compare and enable control
  always_comb begin
    dst_d = dst_q;
    if (exec && !is_gie && (op != compare_op)) begin
      dst_d = exec_res;
    end else if (do_write && hit_dst) begin
      dst_d = merge(dst_q, wdata_q, wstrb_q);
    end
  end

  // Status word: flags, enable bit, or a software write
  always_comb begin
    psw_d = psw_q;
    if (exec && (op == interrupt_disable_op)) begin
      psw_d = psw_q & ~GIE_MASK;
    end else if (exec && (op == interrupt_enable_op)) begin
      psw_d = psw_q | GIE_MASK;
    end else if (exec) begin
      psw_d = flag_psw;
    end else if (do_write && hit_psw) begin
      psw_d = merge(psw_q, wdata_q, wstrb_q);
    end
  end

  assign src_d = (do_write && hit_src) ? merge(src_q, wdata_q, wstrb_q) : src_q;

  // Read multiplexer
  wire rd_src = (axi_req.araddr == OFF_SRC);
  wire rd_dst = (axi_req.araddr == OFF_DST);
  wire rd_psw = (axi_req.araddr == OFF_PSW);
  wire rd_cmd = (axi_req.araddr == OFF_CMD);
  wire rd_state = (axi_req.araddr == OFF_STATE);
  wire rd_mapped = rd_src || rd_dst || rd_psw || rd_cmd || rd_state;
  wire [WORD_W-1:0] rd_word = rd_src ? src_q : rd_dst ? dst_q : rd_psw ? psw_q : rd_cmd ? cmd_q :
                              rd_state ? {14'h0000, accept_q, inhibit_q} : ZERO_WORD;

  // ************************************************************
  // Registers
  // ************************************************************
  // Operand and status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= WORD_RESET;
      dst_q <= WORD_RESET;
      psw_q <= PSW_RESET;
      cmd_q <= WORD_RESET;
    end else begin
      src_q <= src_d;
      dst_q <= dst_d;
      psw_q <= psw_d;
      cmd_q <= exec ? wdata_q[WORD_W-1:0] : cmd_q;
    end
  end

  // Write channel: address and data held in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= axi_req.awaddr;
      end
      if (w_hs) begin
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      aw_have_q <= aw_hs ? 1'b1 : (do_write ? 1'b0 : aw_have_q);
      w_have_q <= w_hs ? 1'b1 : (do_write ? 1'b0 : w_have_q);
      awready_q <= aw_hs ? 1'b0 : (b_hs ? 1'b1 : awready_q);
      wready_q <= w_hs ? 1'b0 : (b_hs ? 1'b1 : wready_q);
      bvalid_q <= do_write ? 1'b1 : (b_hs ? 1'b0 : bvalid_q);
      if (do_write) begin
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read channel: data answered at the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ar_hs ? 1'b0 : (r_hs ? 1'b1 : arready_q);
      rvalid_q <= ar_hs ? 1'b1 : (r_hs ? 1'b0 : rvalid_q);
      if (ar_hs) begin
        rdata_q <= {16'h0000, rd_word};
        rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Interrupt gating: held off for one instruction after enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
      inhibit_q <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_request;
      irq_sync_q <= irq_meta_q;
      inhibit_q <= exec ? (op == interrupt_enable_op) : inhibit_q;
      // Built from the registered enable bit, so it lags a disable by one cycle
      accept_q <= psw_q[PSW_GIE] && irq_sync_q && !inhibit_q;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign axi_rsp.awready = awready_q;
  assign axi_rsp.wready = wready_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = arready_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign irq_accept = accept_q;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_exec_word(cbx_op_e o);
    exec && (op == o) && !byte_mode;
  endsequence
  sequence s_interrupt_enable_op;
    exec && (op == interrupt_enable_op);
  endsequence

  chk_cmp_no_store: assert property (@(posedge aclk) disable iff (!aresetn)
    s_exec_word(compare_op) |=> (dst_q == $past(dst_q)) && (src_q == $past(src_q)))
    else $error("compare changed an operand");
  chk_cmp_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    s_exec_word(compare_op) |=> (psw_q[PSW_C] == ($past(dst_q) >= $past(src_q))) &&
      (psw_q[PSW_Z] == ($past(dst_q) == $past(src_q))))
    else $error("compare flags wrong");
  chk_mode_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && !is_gie |=> psw_q[PSW_OSCILLATOR_OFF_BIT:PSW_GIE] == $past(psw_q[PSW_OSCILLATOR_OFF_BIT:PSW_GIE]))
    else $error("mode bits changed");
  chk_bcd_carry_in_op_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    s_exec_word(bcd_carry_in_op) ##0 psw_q[PSW_C] && (dst_q == BCD_WORD_MAX) |=>
      (dst_q == ZERO_WORD) && psw_q[PSW_C] && psw_q[PSW_Z])
    else $error("decimal wrap wrong");
  chk_dec_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    s_exec_word(subtract_one_op) |=> (psw_q[PSW_Z] == ($past(dst_q) == 16'h0001)) &&
      (psw_q[PSW_C] == ($past(dst_q) != ZERO_WORD)) && (psw_q[PSW_V] == ($past(dst_q) == 16'h8000)))
    else $error("subtract one flags wrong");
  chk_subtract_two_op_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    s_exec_word(subtract_two_op) |=> (dst_q == $past(dst_q) - 16'h0002) &&
      (psw_q[PSW_C] == ($past(dst_q) > 16'h0001)) &&
      (psw_q[PSW_V] == (($past(dst_q) == 16'h8000) || ($past(dst_q) == 16'h8001))))
    else $error("subtract two wrong");
  chk_inc_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    s_exec_word(increment_op) |=> (psw_q[PSW_C] == ($past(dst_q) == 16'hffff)) &&
      (psw_q[PSW_V] == ($past(dst_q) == 16'h7fff)))
    else $error("increment flags wrong");
  chk_byte_high: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && byte_mode && !is_gie && (op != compare_op) |=> dst_q[15:8] == 8'h00)
    else $error("byte form touched high byte");
  chk_interrupt_disable_op_gie: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && (op == interrupt_disable_op) |=> psw_q == ($past(psw_q) & ~GIE_MASK))
    else $error("disable changed other bits");
  chk_interrupt_enable_op_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_interrupt_enable_op |=> psw_q[PSW_GIE] && inhibit_q ##1 !accept_q)
    else $error("interrupt accepted right after enable");

endmodule

/* test/cbx_exec_tb.sv */
// Self-checking bench for the execution slice, driven over its register bus
`timescale 1ns/1ns
module cbx_exec_tb;
  import cbx_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic irq_request = 1'b0;
  logic irq_accept;
  cbx_axi_req_s rq = '0;
  cbx_axi_rsp_s rs;
  int failures = 0;
  int n_compared = 0;
  // Boundary operands for the step operations
  logic [15:0] corner [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h8000, 16'h8001, 16'h7fff, 16'hffff, 16'h0080,
    16'h0081, 16'h007f, 16'h00ff};

  cbx_exec dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq), .axi_rsp(rs), .irq_request(irq_request),
    .irq_accept(irq_accept));

  always #50 aclk = ~aclk;

  task automatic final_report;
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    rq.awvalid <= 1'b1;
    rq.awaddr <= a;
    rq.wvalid <= 1'b1;
    rq.wdata <= d;
    rq.wstrb <= 4'hf;
    rq.bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (rq.awvalid && rs.awready) rq.awvalid <= 1'b0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 1'b0;
      if (rs.bvalid) break;
    end
    if (k == 50) begin
      failures++;
      final_report();
    end
    r = rs.bresp;
    rq.bready <= 1'b0;
  endtask

  // One read: address dropped once taken, ready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    rq.arvalid <= 1'b1;
    rq.araddr <= a;
    rq.rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (rq.arvalid && rs.arready) rq.arvalid <= 1'b0;
      if (rs.rvalid) break;
    end
    if (k == 50) begin
      failures++;
      final_report();
    end
    d = rs.rdata;
    r = rs.rresp;
    rq.rready <= 1'b0;
  endtask

  // Expected {destination, status word} after one command
  function automatic logic [31:0] model(input logic [2:0] op, input logic bm, input logic [15:0] s,
    input logic [15:0] d, input logic [15:0] p);
    logic [15:0] m, sb, dd, a, res, nd;
    logic [16:0] r;
    logic [4:0] dg;
    logic c, v;
    int i;
    m = bm ? 16'h00ff : 16'hffff;
    sb = bm ? 16'h0080 : 16'h8000;
    dd = d & m;
    a = (op == 3'd0) ? ~s & m : (op == 3'd3) ? m : (op == 3'd4) ? m & 16'hfffe : 16'h0001;
    r = dd + a + 17'(op == 3'd0);
    c = bm ? r[8] : r[16];
    v = ((dd ^ ~a) & (dd ^ r[15:0]) & sb) != 16'h0000;
    // Decimal ops: digit-wise add, overflow flag kept
    if (op == 3'd1 || op == 3'd2) begin
      c = p[0];
      v = p[8];
      r = '0;
      for (i = 0; i < (bm ? 2 : 4); i++) begin
        dg = dd[4*i+:4] + (op == 3'd1 ? s[4*i+:4] : 4'h0) + 5'(c);
        c = dg > 5'h09;
        if (c) dg = dg + 5'h06;
        r[4*i+:4] = dg[3:0];
      end
    end
    res = r[15:0] & m;
    nd = (op == 3'd0 || op[2:1] == 2'b11) ? d : res;
    if (op[2:1] == 2'b11) return {nd, op[0] ? p | GIE_MASK : p & ~GIE_MASK};
    return {nd, p[15:9], v, p[7:3], (res & sb) != 16'h0000, res == 16'h0000, c};
  endfunction

  initial begin
    logic [2:0] op;
    logic bm, q;
    logic [15:0] s, d, p;
    logic [31:0] e, g;
    logic [1:0] r;
    int n, i;
    void'($urandom(32'h21df));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_PSW, g, r);
    chk("psw_reset", {16'h0000, PSW_RESET}, g);
    // Every operation in word and byte form, random and boundary operands
    for (n = 0; n < 240; n++) begin
      op = n[2:0];
      bm = n[3];
      s = 16'($urandom);
      d = (n % 3 == 0) ? corner[$urandom % 11] : 16'($urandom);
      if (op == 3'd1 || op == 3'd2) begin
        for (i = 0; i < 4; i++) begin
          s[4*i+:4] = 4'($urandom % 10);
          d[4*i+:4] = 4'($urandom % 10);
        end
        if (n % 5 == 0) d = 16'h9999;
      end
      p = 16'($urandom) & 16'h013f;
      q = 1'($urandom);
      irq_request <= q;
      wr(OFF_SRC, {16'h0000, s}, r);
      wr(OFF_DST, {16'h0000, d}, r);
      wr(OFF_PSW, {16'h0000, p}, r);
      wr(OFF_CMD, {23'h0, bm, 5'h00, op}, r);
      e = model(op, bm, s, d, p);
      rd(OFF_DST, g, r);
      chk("dst", {16'h0000, e[31:16]}, g);
      rd(OFF_PSW, g, r);
      chk("psw", {16'h0000, e[15:0]}, g);
      rd(OFF_CMD, g, r);
      chk("cmd", {23'h0, bm, 5'h00, op}, g);
      repeat (4) @(posedge aclk);
      chk("irq_accept", {31'h0, q & e[PSW_GIE] & (op != 3'd7)}, {31'h0, irq_accept});
      rd(OFF_STATE, g, r);
      chk("state", {30'h0, q & e[PSW_GIE] & (op != 3'd7), op == 3'd7}, g);
    end
    // Unmapped place on both channels, and the read-only state word on the write channel
    wr(8'h20, 32'h0000_0001, r);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(OFF_STATE, 32'h0000_0003, r);
    chk("bresp_state", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(8'h20, g, r);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata_unmapped", 32'h0000_0000, g);
    // Reset in mid-run returns the operands and the gate to their reset state
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_DST, g, r);
    chk("dst_reset", {16'h0000, WORD_RESET}, g);
    chk("irq_accept_reset", 32'h0000_0000, {31'h0, irq_accept});
    final_report();
  end
endmodule
